// ==== hdl/lrg_defines.vh ====
// constants for the phy-side grant and closing-request encoding block
`ifndef LRG_DEFINES_VH
`define LRG_DEFINES_VH
// ==========================================
// interface control line states
`define LRG_CTL_IDLE 2'h0
`define LRG_CTL_STATUS 2'h1
`define LRG_CTL_TRANSMIT 2'h1
`define LRG_CTL_RECEIVE 2'h2
`define LRG_CTL_HOLD 2'h3
`define LRG_CTL_GRANT 2'h3
// ==========================================
// data bit positions
`define LRG_FMT_BIT 0
`define LRG_KIND_LO 1
`define LRG_KIND_HI 3
`define LRG_SUBEND_BIT 4
`define LRG_SPD_LO 5
`define LRG_SPD_HI 6
// ==========================================
// closing request codes
`define LRG_REQ_NONE 3'h0
`define LRG_REQ_ISO_ODD 3'h1
`define LRG_REQ_ISO_EVEN 3'h2
`define LRG_REQ_CURRENT 3'h3
`define LRG_REQ_NEXT_EVEN 3'h4
`define LRG_REQ_NEXT_ODD 3'h5
`define LRG_REQ_CYC_START 3'h6
`define LRG_REQ_RSVD 3'h7
// ==========================================
// grant kind codes
`define LRG_GNT_ISO 3'h2
`define LRG_GNT_ASYNC 3'h5
`define LRG_GNT_CYC_START 3'h6
`define LRG_GNT_IMMED 3'h7
// ==========================================
// timing
`define LRG_LINK_WAIT_CYCLES 4'h8
// pin synchroniser latency; the first wait cycles still see our own drive
`define LRG_SYNC_DEPTH 4'h2
// ==========================================
// reset values
`define LRG_DATA_RST 8'h00
`define LRG_CTL_RST 2'h0
`endif

// ==== hdl/lrg_sync.v ====
// two-flop synchroniser for a bus of pin inputs
`timescale 1ns/1ps
module lrg_sync #(
	parameter W = 1
) (
	// clock and reset
	input wire clk,
	input wire rst_n,
	// data
	input wire [W-1:0] d,
	output reg [W-1:0] q
);
	reg [W-1:0] meta;
	// ==========================================
	// synchroniser flops; meta is read only by q
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			meta <= {W{1'b0}};
			q <= {W{1'b0}};
		end else begin
			meta <= d;
			q <= meta;
		end
	end
endmodule // lrg_sync

// ==== hdl/lrg_grant.v ====
// phy side: grant cycle drive, link wait, closing hold request decode
`timescale 1ns/1ps
`include "lrg_defines.vh"
module lrg_grant (
	// clock and reset
	input wire clk,
	input wire rst_n,
	// arbitration side
	input wire arb_won,
	input wire [2:0] arb_kind,
	input wire [1:0] arb_speed,
	input wire arb_beta,
	// interface pins, inputs from the link
	input wire [1:0] interface_control_lines_in,
	input wire [7:0] data_in,
	// interface pins, phy drive
	output reg [1:0] interface_control_lines_out,
	output reg interface_control_lines_oe,
	output reg [7:0] data_out,
	output reg data_oe,
	// status towards arbitration
	output reg grant_busy,
	output reg link_timeout,
	output reg link_took_bus,
	output reg req_valid,
	output reg [2:0] closing_request_code,
	output reg [1:0] req_speed,
	output reg req_beta,
	output reg subaction_end,
	output reg req_reserved
);
	// ==========================================
	// interface ownership states
	localparam ST_OWN = 3'h0;
	localparam ST_GRANT = 3'h1;
	localparam ST_GAP = 3'h2;
	localparam ST_WAIT = 3'h3;
	localparam ST_LINK = 3'h4;

	reg [2:0] state;
	reg [2:0] next_state;
	reg [3:0] wait_cnt;
	reg [1:0] prev_ctl;
	reg [7:0] hold_data;
	reg pend_hold;
	wire [1:0] ctl_s;
	wire [7:0] dat_s;
	wire [7:0] grant_word;
	wire link_active;
	wire echo_done;
	wire wait_last;

	// ==========================================
	// legal grant kinds; reserved ones are never issued
	function kind_legal;
		input [2:0] k;
		begin
			kind_legal = (k == `LRG_GNT_ISO) || (k == `LRG_GNT_ASYNC) ||
				(k == `LRG_GNT_CYC_START) || (k == `LRG_GNT_IMMED);
		end
	endfunction

	// ==========================================
	// pin synchronisers
	// every link state reaches the decode two edges after it stood on the pins
	lrg_sync #(.W(10)) u_sync (
		.clk(clk),
		.rst_n(rst_n),
		.d({interface_control_lines_in, data_in}),
		.q({ctl_s, dat_s})
	);

	// ==========================================
	// grant word and link wait decode
	// kind, speed and format all land on the data lines in one word
	assign grant_word = {1'b0, arb_speed, 1'b0, arb_kind, arb_beta};
	// the first wait cycles still see our own grant and gap through the
	// synchroniser; without the mask the grant echo reads as a link hold
	assign echo_done = (wait_cnt >= `LRG_SYNC_DEPTH);
	assign link_active = echo_done &&
		((ctl_s == `LRG_CTL_HOLD) || (ctl_s == `LRG_CTL_TRANSMIT));
	// eight link cycles, counted from the first cycle the link owns the pins
	assign wait_last =
		(wait_cnt == `LRG_LINK_WAIT_CYCLES + `LRG_SYNC_DEPTH - 4'h1);

	// ==========================================
	// interface ownership
	always @* begin
		next_state = state;
		case (state)
			ST_OWN: begin
				if (arb_won && kind_legal(arb_kind))
					next_state = ST_GRANT;
			end
			ST_GRANT: begin
				next_state = ST_GAP;
			end
			ST_GAP: begin
				next_state = ST_WAIT;
			end
			ST_WAIT: begin
				if (link_active)
					next_state = ST_LINK;
				else if (wait_last)
					next_state = ST_OWN;
			end
			ST_LINK: begin
				// link ends with hold or idle then releases; idle after transmit means done
				// a link that never returns to idle keeps the pins; there is no watchdog
				if (ctl_s == `LRG_CTL_IDLE && prev_ctl != `LRG_CTL_IDLE)
					next_state = ST_OWN;
			end
			default: begin
				next_state = ST_OWN;
			end
		endcase
	end

	// ==========================================
	// ownership state, wait counter, busy level and status pulses
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state <= ST_OWN;
			wait_cnt <= 4'h0;
			prev_ctl <= `LRG_CTL_RST;
			grant_busy <= 1'b0;
			link_timeout <= 1'b0;
			link_took_bus <= 1'b0;
		end else begin
			state <= next_state;
			prev_ctl <= ctl_s;
			wait_cnt <= (state == ST_WAIT) ? wait_cnt + 4'h1 : 4'h0;
			link_timeout <= (state == ST_WAIT) && (next_state == ST_OWN);
			link_took_bus <= (state == ST_WAIT) && (next_state == ST_LINK);
			grant_busy <= (next_state != ST_OWN);
		end
	end

	// ==========================================
	// pins: drive grant word one cycle, idle one cycle, then release
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			interface_control_lines_out <= `LRG_CTL_RST;
			interface_control_lines_oe <= 1'b1;
			data_out <= `LRG_DATA_RST;
			data_oe <= 1'b1;
		end else begin
			case (next_state)
				ST_GRANT: begin
					interface_control_lines_out <= `LRG_CTL_GRANT;
					data_out <= grant_word;
					interface_control_lines_oe <= 1'b1;
					data_oe <= 1'b1;
				end
				ST_WAIT, ST_LINK: begin
					interface_control_lines_out <= `LRG_CTL_IDLE;
					data_out <= `LRG_DATA_RST;
					interface_control_lines_oe <= 1'b0;
					data_oe <= 1'b0;
				end
				default: begin
					interface_control_lines_out <= `LRG_CTL_IDLE;
					data_out <= `LRG_DATA_RST;
					interface_control_lines_oe <= 1'b1;
					data_oe <= 1'b1;
				end
			endcase
		end
	end

	// ==========================================
	// closing hold decode
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			hold_data <= `LRG_DATA_RST;
			pend_hold <= 1'b0;
			req_valid <= 1'b0;
			closing_request_code <= `LRG_REQ_NONE;
			req_speed <= 2'h0;
			req_beta <= 1'b0;
			subaction_end <= 1'b0;
			req_reserved <= 1'b0;
		end else begin
			// a hold straight after transmit is the closing hold; its word is
			// decoded when the following idle confirms the end of the packet
			req_valid <= 1'b0;
			if (state == ST_LINK) begin
				if (ctl_s == `LRG_CTL_HOLD && prev_ctl == `LRG_CTL_TRANSMIT) begin
					pend_hold <= 1'b1;
					hold_data <= dat_s;
				end else if (ctl_s == `LRG_CTL_IDLE && pend_hold) begin
					pend_hold <= 1'b0;
					// advisory only: arbitration may drop it, nothing here forces a grant
					req_valid <= 1'b1;
					closing_request_code <= hold_data[`LRG_KIND_HI:`LRG_KIND_LO];
					req_reserved <= (hold_data[`LRG_KIND_HI:`LRG_KIND_LO] ==
						`LRG_REQ_RSVD);
					req_speed <= hold_data[`LRG_SPD_HI:`LRG_SPD_LO];
					req_beta <= hold_data[`LRG_FMT_BIT];
					subaction_end <= hold_data[`LRG_SUBEND_BIT];
				end
			end else begin
				pend_hold <= 1'b0;
			end
		end
	end
endmodule // lrg_grant

// ==== bench/lrg_assertions.sv ====
// port assertions for the grant block
`timescale 1ns/1ps
module lrg_chk (
	// clock
	input wire clk,
	input wire rst_n,
	// in
	input wire [2:0] arb_kind,
	input wire [1:0] arb_speed,
	input wire arb_beta,
	// out
	input wire [1:0] interface_control_lines_out,
	input wire interface_control_lines_oe,
	input wire [7:0] data_out,
	input wire data_oe,
	input wire grant_busy,
	input wire link_timeout,
	input wire link_took_bus,
	input wire req_valid,
	input wire [2:0] closing_request_code,
	input wire req_reserved
);
	wire [7:0] word = {1'h0, arb_speed, 1'h0, arb_kind, arb_beta};
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);
	property p_gw; $rose(grant_busy) |-> data_out == $past(word); endproperty
	a_gw: assert property (p_gw) else $error("grant word");
	property p_gk; $rose(grant_busy) |-> data_out[3:1] inside {3'h2, 3'h5, 3'h6, 3'h7}; endproperty
	a_gk: assert property (p_gk) else $error("grant kind");
	property p_gi; $rose(grant_busy) |-> interface_control_lines_out == 2'h3
		##1 interface_control_lines_out == 2'h0 && data_oe
		##1 !interface_control_lines_oe && !data_oe; endproperty
	a_gi: assert property (p_gi) else $error("grant idle");
	property p_to; link_timeout |-> $past(grant_busy, 12) && !$past(grant_busy, 13); endproperty
	a_to: assert property (p_to) else $error("timeout");
	property p_tr; link_timeout |-> interface_control_lines_oe && !grant_busy; endproperty
	a_tr: assert property (p_tr) else $error("reclaim");
	property p_tk; link_took_bus |-> grant_busy && !interface_control_lines_oe; endproperty
	a_tk: assert property (p_tk) else $error("taken");
	property p_rb; req_valid |-> interface_control_lines_oe && !grant_busy; endproperty
	a_rb: assert property (p_rb) else $error("return");
	property p_rr; req_valid |-> req_reserved == (closing_request_code == 3'h7); endproperty
	a_rr: assert property (p_rr) else $error("reserved");
endmodule // lrg_chk
bind lrg_grant lrg_chk lrg_chk_i (.*);

// ==== bench/lrg_link.sv ====
// link controller model on the far side of the pins
`timescale 1ns/1ps
module lrg_link (
	// pins
	input wire clk,
	input wire [1:0] interface_control_lines_out,
	input wire interface_control_lines_oe,
	input wire [7:0] data_out,
	output reg [1:0] ctl_lk,
	output reg [7:0] data_lk,
	// pending request
	input wire [6:0] want,
	input wire [7:0] req_word,
	input wire [3:0] dly
);
	initial {ctl_lk, data_lk} = 10'h000;
	// a grant that does not match is left to time out; an ungranted request is dropped
	always @(posedge clk)
		if (interface_control_lines_oe && interface_control_lines_out == 2'h3
			&& data_out[6:0] == want) begin
			repeat (dly + 1) @(posedge clk);
			{ctl_lk, data_lk} <= {2'h1, 8'h5a};
			@(posedge clk);
			{ctl_lk, data_lk} <= {2'h3, req_word};
			@(posedge clk);
			{ctl_lk, data_lk} <= 10'h000;
			@(posedge clk);
			data_lk <= ~req_word; // released lines must not keep the request
		end
endmodule // lrg_link

// ==== bench/lrg_tb.sv ====
// bench: every grant kind, matched and unmatched by the link model
`timescale 1ns/1ps
module testbench;
	reg clk, rst_n, arb_won, arb_beta;
	reg [2:0] arb_kind;
	reg [1:0] arb_speed;
	reg [6:0] want;
	reg [7:0] req_word;
	reg [3:0] dly;
	wire [1:0] interface_control_lines_out, interface_control_lines_in, ctl_lk, req_speed;
	wire [7:0] data_out, data_in, data_lk;
	wire [2:0] closing_request_code;
	wire interface_control_lines_oe, data_oe, grant_busy, link_timeout, link_took_bus, req_valid;
	wire req_beta, subaction_end, req_reserved;
	integer n_mismatch = 0, checks_done = 0, i, j, seen_to, seen_rv;
	// the enabled side owns the pins
	assign interface_control_lines_in =
		interface_control_lines_oe ? interface_control_lines_out : ctl_lk;
	assign data_in = data_oe ? data_out : data_lk;
	lrg_grant lrg_grant_i (.*);
	lrg_link lrg_link_i (.*);
	initial begin
		clk = 1'h0;
		forever #20 clk = ~clk;
	end
	task chk(input bit c);
		checks_done = checks_done + 1;
		if (!c) begin
			n_mismatch = n_mismatch + 1;
			$display("wrong value at %0t in check %0d", $time, checks_done);
		end
	endtask
	task final_report;
		if (n_mismatch == 0 && checks_done > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	// one win; m says whether the link's pending request matches the grant
	task run(input [2:0] k, input bit m);
		reg lg;
		lg = (k == 3'h2 || k > 3'h4);
		want <= {k[1:0], 1'h0, k, k[0]} ^ {!m, 6'h00};
		req_word <= {1'h0, ~k[1:0], k[0], k, ~k[0]};
		dly <= k[0] ? 4'h3 : 4'h0;
		{arb_won, arb_kind, arb_speed, arb_beta} <= {1'h1, k, k[1:0], k[0]};
		@(posedge clk);
		arb_won <= 1'h0;
		#1 chk(grant_busy === lg);
		{seen_to, seen_rv} = 0;
		for (i = 0; i < 24; i = i + 1) begin
			@(posedge clk);
			#1 seen_to = seen_to | link_timeout;
			if (req_valid === 1'h1) begin
				seen_rv = 1;
				chk({req_reserved, req_speed, subaction_end, closing_request_code, req_beta}
					=== {k == 3'h7, req_word[6:0]});
			end
		end
		chk(seen_to === (lg && !m));
		chk(seen_rv === (lg && m));
		if (grant_busy !== 1'h0) begin
			chk(1'h0);
			final_report;
		end
		@(posedge clk);
	endtask
	initial begin
		{rst_n, arb_won, arb_kind, arb_speed, arb_beta, want, req_word, dly} = 0;
		repeat (6) @(posedge clk);
		rst_n <= 1'h1;
		for (j = 0; j < 16; j = j + 1)
			run(j[2:0], j < 8);
		// a reset in mid-wait hands the pins straight back to the phy
		{arb_won, arb_kind} <= {1'h1, 3'h6};
		@(posedge clk);
		arb_won <= 1'h0;
		repeat (3) @(posedge clk);
		rst_n <= 1'h0;
		@(posedge clk);
		#1 chk({interface_control_lines_oe, data_oe, grant_busy} === 3'h6);
		@(posedge clk);
		rst_n <= 1'h1;
		run(3'h5, 1'h1);
		final_report;
	end
endmodule // testbench
